/* File: hw/framer_pkg.sv */
// Types and byte coders shared by the video line framer.
// Assumes framer_regs.svh is on the include path.
`include "framer_regs.svh"
package framer_pkg;
  typedef enum logic [1:0] {
    fmt_ntsc = 2'h0, fmt_pal = 2'h1, fmt_cif = 2'h2, fmt_qcif = 2'h3
  } fmt_t;
  // Three type bits of the command byte
  typedef enum logic [2:0] {
    line_end_type = 3'h0, blank_line_type = 3'h1, black_line_type = 3'h2,
    visible_line_type = 3'h3, even_field_start_code = 3'h4,
    even_field_end_code = 3'h5, odd_field_start_code = 3'h6, odd_field_end_code = 3'h7
  } line_kind_t;

  // Fixed one, type bits, then four even-parity check bits
  function automatic logic [7:0] cmd_byte(input line_kind_t k);
    logic [2:0] c;
    c = k;
    return {1'b1, c, c[1] ^ c[0], c[2] ^ c[0], c[2] ^ c[1], c[2] ^ c[1] ^ c[0]};
  endfunction

  // Leading zero, six number bits, odd parity bit
  function automatic logic [7:0] ln_byte(input logic [5:0] half);
    return {1'b0, half, ~^half};
  endfunction

  // Keeps pixels off the values that could mimic an escape
  function automatic logic [9:0] clip_pix(input logic [9:0] v, input logic wide);
    logic [9:0] lo;
    logic [9:0] hi;
    lo = wide ? `CLIP_LO10 : `CLIP_LO8;
    hi = wide ? `CLIP_HI10 : `CLIP_HI8;
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
endpackage

/* File: hw/framer_regs.svh */
// Constants of the video line framer: sequence bytes, line counts, clip limits.
// Assumes inclusion by bare name from the package; the framer uses the macros without including it.
`ifndef FRAMER_REGS_SVH
`define FRAMER_REGS_SVH
// Control sequence bytes and positions
`define ESC_BYTE 8'hff
`define SYNC_BYTE 8'h00
`define CLOSE_LAST_BYTE 8'hff
`define SEQ_SYNC 3'h2
`define SEQ_CMD 3'h3
`define SEQ_SUPP_A 3'h4
`define SEQ_LAST 3'h5
`define BLANK_PIX 10'h01c
`define BLANK_BYTE 8'h07
// Field lengths per format and field
`define LEN_NTSC_0 9'h106
`define LEN_NTSC_1 9'h107
`define LEN_PAL_0 9'h138
`define LEN_PAL_1 9'h139
`define LEN_CIF 9'h140
`define LEN_QCIF 9'h0a0
// Active lines per field
`define ACT_NTSC 9'h0f4
`define ACT_PAL 9'h124
`define ACT_QCIF 9'h094
// Leading black, blank and dark line counts
`define BLK_EXTRA 9'h008
`define BLK_MIN 9'h002
`define BLK_WIDE 9'h010
`define BLANK_EXTRA 9'h001
`define BLANK_MIN 9'h007
`define DARK_NTSC 9'h008
`define DARK_SHORT 9'h002
`define DARK_CIF 9'h00a
// Pixel average windows and output clip limits
`define AVG_WIDE 10'h100
`define AVG_NARROW 10'h080
`define CLIP_LO10 10'h001
`define CLIP_HI10 10'h3fe
`define CLIP_LO8 10'h004
`define CLIP_HI8 10'h3fb
`endif

/* File: hw/line_average.sv */
// Accumulates the central pixels of a line and presents their mean.
// Assumes the caller gates samples to the window and clears between lines.
module line_average #(
  parameter int WIDTH = 10
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic sample_en,
  input wire logic [WIDTH-1:0] sample,
  input wire logic narrow,
  output logic [WIDTH-1:0] mean
);
  if (WIDTH < 2) begin : g_chk
    $error("line_average needs WIDTH of at least two");
  end
  logic [WIDTH+7:0] sum_q;
  // Window sizes are powers of two, so the mean is a plain shift
  assign mean = narrow ? sum_q[WIDTH+6:7] : sum_q[WIDTH+7:8];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sum_q <= '0;
    end else if (clear) begin
      sum_q <= '0;
    end else if (sample_en) begin
      sum_q <= sum_q + (WIDTH+8)'(sample);
    end
  end
endmodule

/* File: hw/skid_buffer.sv */
// Two-entry buffer with valid and ready on both sides; all outputs are flops.
// Assumes one clock and an active-low asynchronous reset.
module skid_buffer #(
  parameter int WIDTH = 10
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  if (WIDTH < 1) begin : g_chk
    $error("skid_buffer needs WIDTH of at least one");
  end
  logic sk_valid_q;
  logic ready_q;
  logic [WIDTH-1:0] sk_data_q;
  logic out_valid_q;
  logic [WIDTH-1:0] out_data_q;
  // Ready is registered, so the second entry catches the word in flight
  // It mirrors an empty second entry but has its own flop, so the port is a flop
  assign in_ready = ready_q;
  assign out_valid = out_valid_q;
  assign out_data = out_data_q;

  // Head moves when drained or empty; otherwise an arriving word parks
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
      sk_valid_q <= 1'b0;
      ready_q <= 1'b1;
      sk_data_q <= '0;
    end else if (out_ready || !out_valid_q) begin
      out_valid_q <= sk_valid_q || in_valid;
      out_data_q <= sk_valid_q ? sk_data_q : in_data;
      sk_valid_q <= 1'b0;
      ready_q <= 1'b1;
    end else if (in_valid && in_ready) begin
      sk_valid_q <= 1'b1;
      ready_q <= 1'b0;
      sk_data_q <= in_data;
    end
  end

  hold_word_a: assert property (@(posedge clk) disable iff (!reset_n)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("buffer dropped or changed a stalled word");
endmodule

/* File: hw/video_line_framer.sv */
// Video line framer: builds fields of framed lines for the sensor output.
// Assumes pixels arrive in line order on pix_data and the host drains out_data.
// Contract
// R1: Line-open supplementary bytes carry the 12-bit line number in two halves.
// R2: Each half gets a leading zero and a trailing odd-parity bit.
// R3: Close byte five holds the mean of the central 256 or 128 pixels.
// R4: Close byte six is all ones.
// R5: Five-wire words carry control bytes in the top eight bits, low two zero.
// R6: Command byte is one, three type bits, four check bits.
// R7: Odd-field codes appear only in PAL and NTSC.
// R8: Five-wire command words split into the listed upper and lower pairs.
// R9: Host accepts type bits when a single check fails.
// R10: Host inverts the data bit named by a failing check triple.
// R11: Host flags every other failure pattern as a two-bit error.
// R12: Two fields per frame, each in the fixed order of line kinds.
// R13: Active and total line counts per field follow the format.
// R14: Compatible layout gives 8 black and 1 blank, or 2 black and 7 blank.
// R15: Without compatible layout no blank lines; black and dark lines instead.
// R16: Line number is zero on the start line and rises by one.
// R17: Every line opens with its type sequence and closes with line end.
// R18: Blank lines carry only blanking pixels.
// R19: Black lines are built like active lines; here they carry blanking pixels like blank lines.
// R20: Dark lines carry the black line code.
// R21: Each control sequence is six bytes: prefix, command, two extra bytes.
// R22: The prefix is all ones, all ones, zero.
// R23: Check bits give even parity over the four groups.
// R24: First extra byte carries the upper six bits, second the lower.
module video_line_framer
  import framer_pkg::*;
#(
  parameter int PIX_FULL = 352,
  parameter int PIX_QUARTER = 176
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  input wire fmt_t video_format,
  input wire logic compat_line_layout,
  input wire logic extra_black_en,
  input wire logic five_wire_mode,
  input wire logic [9:0] pix_data,
  input wire logic pix_valid,
  output logic pix_ready,
  output logic [9:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output line_kind_t line_kind,
  output logic field_second,
  output logic [11:0] line_number
);
  if (PIX_FULL < 256 || PIX_FULL > 1023 || PIX_QUARTER < 128 || PIX_QUARTER > 1023) begin : g_chk
    $error("line widths must cover the average window and fit ten bits");
  end

  typedef enum logic [1:0] {
    st_idle = 2'h0, st_open = 2'h1, st_body = 2'h2, st_close = 2'h3
  } state_t;

  state_t state_q, state_d;
  logic [2:0] seq_q, seq_d;
  logic [9:0] pix_q, pix_d;
  logic [8:0] line_q, line_d;
  logic field_q, field_d;
  fmt_t fmt_q;
  logic compat_q, extra_q, five_q;
  line_kind_t kind_q;
  logic [11:0] number_q;

  // Geometry of the current field, from the configuration latched at its start
  logic wide_fmt, qcif, use_odd, trail_blank;
  logic [8:0] field_len, n_black, n_blank, n_dark, n_act;
  logic [8:0] blank_at, dark_at, act_at, eof_at;
  assign wide_fmt = fmt_q == fmt_pal || fmt_q == fmt_cif;
  assign qcif = fmt_q == fmt_qcif;
  assign use_odd = field_q && (fmt_q == fmt_ntsc || fmt_q == fmt_pal); // R7
  assign field_len = fmt_q == fmt_ntsc ? (field_q ? `LEN_NTSC_1 : `LEN_NTSC_0) :
                     fmt_q == fmt_pal ? (field_q ? `LEN_PAL_1 : `LEN_PAL_0) :
                     qcif ? `LEN_QCIF : `LEN_CIF; // R13
  assign n_act = fmt_q == fmt_ntsc ? `ACT_NTSC : (qcif ? `ACT_QCIF : `ACT_PAL); // R13
  assign n_black = !compat_q ? (wide_fmt ? `BLK_WIDE : `BLK_EXTRA) :
                   (extra_q ? `BLK_EXTRA : `BLK_MIN); // R14 R15
  assign n_blank = !compat_q ? 9'h000 : (extra_q ? `BLANK_EXTRA : `BLANK_MIN); // R14 R15
  assign n_dark = compat_q ? 9'h000 : fmt_q == fmt_ntsc ? `DARK_NTSC :
                  fmt_q == fmt_cif ? `DARK_CIF : `DARK_SHORT; // R15
  assign blank_at = 9'h001 + n_black;
  assign dark_at = blank_at + n_blank;
  assign act_at = dark_at + n_dark;
  assign eof_at = act_at + n_act;
  // Only the short-black layout trails with blanking; all others trail black
  assign trail_blank = compat_q && !extra_q;

  // Line kind from position in the field: start, black, blank, dark, active, end, trail
  line_kind_t kind_now;
  logic in_dark;
  assign in_dark = line_q >= dark_at && line_q < act_at;
  assign kind_now = line_q == 9'h000 ? (use_odd ? odd_field_start_code : even_field_start_code) :
                    line_q < blank_at ? black_line_type :
                    line_q < dark_at ? blank_line_type :
                    in_dark ? black_line_type : // R20
                    line_q < eof_at ? visible_line_type :
                    line_q == eof_at ? (use_odd ? odd_field_end_code : even_field_end_code) :
                    (trail_blank ? blank_line_type : black_line_type); // R12

  // Line width and average window for the format
  logic [9:0] line_px, avg_n, win_lo;
  logic pix_last, in_win, seq_last, field_last;
  assign line_px = qcif ? 10'(PIX_QUARTER) : 10'(PIX_FULL);
  assign avg_n = qcif ? `AVG_NARROW : `AVG_WIDE;
  assign win_lo = (line_px - avg_n) >> 1;
  assign in_win = pix_q >= win_lo && pix_q < win_lo + avg_n; // R3
  assign pix_last = pix_q == line_px - 10'h001;
  assign seq_last = seq_q == `SEQ_LAST;
  assign field_last = line_q == field_len - 9'h001;

  // Pixel input through its own buffer so pix_ready comes from a flop
  logic ib_valid, ib_ready;
  logic [9:0] ib_data;
  skid_buffer #(.WIDTH(10)) u_in_buf (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(pix_valid),
    .in_ready(pix_ready),
    .in_data(pix_data),
    .out_valid(ib_valid),
    .out_ready(ib_ready),
    .out_data(ib_data)
  );

  // A word leaves when the output buffer has room and, on picture lines, a pixel waits
  logic ob_ready, emit, is_vis, in_body;
  assign in_body = state_q == st_body;
  assign is_vis = kind_now == visible_line_type;
  assign emit = ob_ready && (state_q == st_open || state_q == st_close ||
                (in_body && (!is_vis || ib_valid)));
  assign ib_ready = in_body && is_vis && ob_ready;

  // Payload: live pixels on visible lines, blanking on every other line kind
  logic [9:0] body_pix, mean;
  assign body_pix = is_vis ? clip_pix(ib_data, five_q) : `BLANK_PIX; // R18 R19

  line_average #(.WIDTH(10)) u_avg (
    .clk(clk),
    .reset_n(reset_n),
    .clear(state_q == st_idle || state_q == st_open),
    .sample_en(emit && in_body && in_win), // R3
    .sample(body_pix),
    .narrow(qcif),
    .mean(mean)
  );

  // Six-byte control sequences: prefix, command, then number or average and ones
  logic [7:0] ctrl_byte, cmd_now, supp_byte;
  logic opening;
  logic [11:0] ln_full;
  assign opening = state_q == st_open;
  // Lines fit nine bits, so the top three bits of the number stay zero
  assign ln_full = {3'h0, line_q};
  assign cmd_now = cmd_byte(opening ? kind_now : line_end_type); // R6 R17 R23
  assign supp_byte = opening ? ln_byte(ln_full[11:6]) : mean[9:2]; // R1 R2 R24 R3
  assign ctrl_byte = seq_q < `SEQ_SYNC ? `ESC_BYTE :
                     seq_q == `SEQ_SYNC ? `SYNC_BYTE : // R21 R22
                     seq_q == `SEQ_CMD ? cmd_now :
                     seq_q == `SEQ_SUPP_A ? supp_byte :
                     opening ? ln_byte(ln_full[5:0]) : `CLOSE_LAST_BYTE; // R1 R24 R4

  // Word on the data bus: control bytes sit high in five-wire mode, low otherwise
  logic [9:0] frame_word;
  assign frame_word = in_body ? (five_q ? body_pix : {2'b00, body_pix[9:2]}) :
                      (five_q ? {ctrl_byte, 2'b00} : {2'b00, ctrl_byte}); // R5 R8

  skid_buffer #(.WIDTH(10)) u_out_buf (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(emit),
    .in_ready(ob_ready),
    .in_data(frame_word),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  // Sequencer: open, body, close for each line; lines and fields wrap here
  always_comb begin
    state_d = state_q;
    seq_d = seq_q;
    pix_d = pix_q;
    line_d = line_q;
    field_d = field_q;
    unique case (state_q)
      st_idle: begin
        if (run) begin
          state_d = st_open;
          seq_d = 3'h0;
          line_d = 9'h000;
          field_d = 1'b0;
        end
      end
      st_open: begin
        if (emit && seq_last) begin
          state_d = st_body;
          seq_d = 3'h0;
          pix_d = 10'h000;
        end else if (emit) begin
          seq_d = seq_q + 3'h1;
        end
      end
      st_body: begin
        if (emit && pix_last) begin
          state_d = st_close;
          seq_d = 3'h0;
        end else if (emit) begin
          pix_d = pix_q + 10'h001;
        end
      end
      st_close: begin
        if (emit && seq_last) begin
          seq_d = 3'h0;
          state_d = run ? st_open : st_idle; // R17
          if (!run || field_last) begin
            line_d = 9'h000;
            field_d = run && !field_q; // R12
          end else begin
            line_d = line_q + 9'h001; // R16
          end
        end else if (emit) begin
          seq_d = seq_q + 3'h1;
        end
      end
    endcase
  end

  // Configuration is taken only at a field start so a field never changes shape
  logic load_cfg;
  assign load_cfg = (state_q == st_idle && run) ||
                    (state_q == st_close && emit && seq_last && field_last);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= st_idle;
      seq_q <= 3'h0;
      pix_q <= 10'h000;
      line_q <= 9'h000;
      field_q <= 1'b0;
    end else begin
      state_q <= state_d;
      seq_q <= seq_d;
      pix_q <= pix_d;
      line_q <= line_d;
      field_q <= field_d;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fmt_q <= fmt_ntsc;
      compat_q <= 1'b1;
      extra_q <= 1'b1;
      five_q <= 1'b0;
    end else if (load_cfg) begin
      fmt_q <= video_format;
      compat_q <= compat_line_layout;
      extra_q <= extra_black_en;
      five_q <= five_wire_mode;
    end
  end

  // Status outputs, registered so they are glitch free for the host
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      kind_q <= even_field_start_code;
      number_q <= 12'h000;
    end else begin
      kind_q <= kind_now;
      number_q <= ln_full;
    end
  end
  assign line_kind = kind_q;
  assign line_number = number_q;
  assign field_second = field_q;

  // Stream checks; each names the rule it guards
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  supp_parity_a: assert property ( // R2
    emit && opening && seq_q >= `SEQ_SUPP_A |-> !ctrl_byte[7] && ^ctrl_byte)
    else $error("line number byte lacks leading zero or odd parity");
  supp_low_half_a: assert property ( // R24
    emit && opening && seq_last |-> ctrl_byte[6:1] == line_q[5:0])
    else $error("second supplementary byte is not the low number half");
  close_ones_a: assert property ( // R4
    emit && state_q == st_close && seq_last |-> ctrl_byte == 8'hff)
    else $error("line close does not end in all ones");
  five_pad_a: assert property ( // R5
    emit && !in_body && five_q |-> frame_word[1:0] == 2'b00 && frame_word[9:2] == ctrl_byte)
    else $error("five-wire control word is misplaced");
  cmd_check_a: assert property ( // R23
    emit && seq_q == `SEQ_CMD |-> ctrl_byte[7] && !(^{ctrl_byte[6:4], ctrl_byte[0]}) &&
      !(^{ctrl_byte[6:5], ctrl_byte[1]}) && !(^{ctrl_byte[6], ctrl_byte[4], ctrl_byte[2]}) &&
      !(^{ctrl_byte[5:4], ctrl_byte[3]}))
    else $error("command byte check bits are wrong");
  no_odd_codes_a: assert property ( // R7
    state_q != st_idle && (fmt_q == fmt_cif || qcif) |-> kind_now[2:1] != 2'b11)
    else $error("odd field code in a format without it");
  line_step_a: assert property ( // R16
    state_q == st_close && emit && seq_last && run && !field_last |=>
      line_q == $past(line_q) + 9'h001 && state_q == st_open && seq_q == 3'h0)
    else $error("line number did not step by one into the next opening");
  field_wrap_a: assert property ( // R12
    state_q == st_close && emit && seq_last && run && field_last |=>
      line_q == 9'h000 && field_q != $past(field_q))
    else $error("field did not wrap to line zero of the other field");
  blank_pixels_a: assert property ( // R18
    emit && in_body && kind_now == blank_line_type |->
      frame_word == (five_q ? `BLANK_PIX : {2'b00, `BLANK_BYTE}))
    else $error("blank line carries a non-blanking pixel");
  short_black_a: assert property ( // R14
    compat_q && !extra_q && line_q >= 9'h003 && line_q <= 9'h008 |-> kind_now == blank_line_type)
    else $error("lines three to eight are not blanking");
  no_blank_a: assert property ( // R15
    state_q != st_idle && !compat_q |-> kind_now != blank_line_type)
    else $error("blank line emitted without compatible layout");
  dark_black_a: assert property ( // R20
    !compat_q && fmt_q == fmt_ntsc && line_q >= 9'h009 && line_q <= 9'h010 |->
      kind_now == black_line_type)
    else $error("dark line is not labelled black");
  escape_free_a: assert property ( // R22
    emit && in_body |-> (five_q ? (frame_word != 10'h3ff && frame_word != 10'h000) :
      frame_word[7:0] != `ESC_BYTE))
    else $error("payload word could pass for an escape");
  trail_kind_a: assert property ( // R12
    state_q != st_idle && line_q > eof_at |->
      kind_now == blank_line_type || kind_now == black_line_type)
    else $error("a line after the field end is neither blank nor black");
  line_hi_a: assert property ( // R24
    emit && opening && seq_q == `SEQ_SUPP_A |-> ctrl_byte[6:1] == ln_full[11:6])
    else $error("first supplementary byte is not the high number half");
  close_cmd_a: assert property ( // R17
    emit && state_q == st_close && seq_q == `SEQ_CMD |-> ctrl_byte == 8'h80)
    else $error("line close does not carry the line end code");

  // Main scenarios: odd fields, stalls, a QCIF wrap, five-wire pixels, extra black
  odd_field_c: cover property (emit && seq_q == `SEQ_CMD && cmd_now == 8'hec);
  stall_c: cover property (out_valid && !out_ready ##1 !ob_ready);
  qcif_wrap_c: cover property (qcif && state_q == st_close && emit && seq_last && field_last);
  five_wire_c: cover property (emit && five_q && in_body && is_vis);
  extra_black_c: cover property (compat_q && extra_q && in_body && kind_now == blank_line_type);
endmodule

/* File: verif/host_sink.sv */
// Host side model: drains the framed stream with periodic stalls and
// checks each command byte the way a receiving host would.
// Assumes one clock shared with the framer and its active-low reset.
module host_sink
  import framer_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [9:0] data,
  input wire logic valid,
  output logic ready,
  input wire logic wide
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] words[$];
  int code_errors;
  logic [4:0] tick_q;
  logic [23:0] last_q;
  logic [7:0] byte_in;
  logic [3:0] code;

  // Failing checks in order P3, P2, P1, P0; result is error flag then type bits
  function automatic logic [3:0] decode(input logic [7:0] b);
    logic [3:0] f;
    f = {^{b[5], b[4], b[3]}, ^{b[6], b[4], b[2]}, ^{b[6], b[5], b[1]}, ^{b[6:4], b[0]}};
    case (f)
      4'h0, 4'h1, 4'h2, 4'h4, 4'h8: return {1'b0, b[6:4]};
      4'hd: return {1'b0, b[6:5], ~b[4]};
      4'hb: return {1'b0, b[6], ~b[5], b[4]};
      4'h7: return {1'b0, ~b[6], b[5:4]};
      default: return 4'h8;
    endcase
  endfunction

  // Five-wire words carry control bytes in their top eight bits
  assign byte_in = wide ? data[9:2] : data[7:0];
  assign code = decode(byte_in);

  // Stall four cycles in every 32, long enough to fill the output buffer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_q <= 5'h00;
      ready <= 1'b0;
    end else begin
      tick_q <= tick_q + 5'h01;
      ready <= tick_q[4:2] != 3'h7;
    end
  end

  // The word after the ones, ones, zero prefix is taken as a command byte
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      words.delete();
      code_errors <= 0;
      last_q <= 24'h000000;
    end else if (valid && ready) begin
      words.push_back(data);
      last_q <= {last_q[15:0], byte_in};
      if (last_q == 24'hffff00 && code[3]) code_errors <= code_errors + 1;
    end
  end
endmodule

/* File: verif/tb_video_line_framer.sv */
// Self-checking bench for the video line framer: drives pixels and
// configuration, lets the host model drain the stream, then walks it.
// Assumes host_sink as the far side and the framer package.
module tb_video_line_framer
  import framer_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic run = 1'b0;
  fmt_t video_format = fmt_qcif;
  logic compat_line_layout = 1'b1;
  logic extra_black_en = 1'b0;
  logic five_wire_mode = 1'b0;
  logic [9:0] pix_data = 10'h000;
  logic pix_valid = 1'b0;
  logic pix_ready, out_valid, out_ready, field_second;
  logic [9:0] out_data;
  line_kind_t line_kind;
  logic [11:0] line_number;
  int errors = 0;
  int checks_done = 0;
  int pos = 0;
  int line_len = 176;
  int pix_idx;
  // Command bytes, and their upper and lower five-bit halves
  localparam logic [7:0] CODE [8] = '{8'h80, 8'h9d, 8'hab, 8'hb6, 8'hc7, 8'hda, 8'hec, 8'hf1};
  localparam logic [9:0] PAIR [8] = '{10'h200, 10'h274, 10'h2ac, 10'h2d8,
                                      10'h31c, 10'h368, 10'h3b0, 10'h3c4};

  always #12.5 clk = ~clk;

  video_line_framer uut (.clk, .reset_n, .run, .video_format, .compat_line_layout,
    .extra_black_en, .five_wire_mode, .pix_data, .pix_valid, .pix_ready, .out_data,
    .out_valid, .out_ready, .line_kind, .field_second, .line_number);

  host_sink sink (.clk, .reset_n, .data(out_data), .valid(out_valid), .ready(out_ready),
    .wide(five_wire_mode));

  // Pixel value depends on its place in the line, so a wrong window shows
  function automatic logic [9:0] pix_at(input int i);
    int win;
    win = (line_len == 176) ? 128 : 256;
    return (i >= (line_len - win) / 2 && i < (line_len + win) / 2) ? 10'h2a8 : 10'h054;
  endfunction

  function automatic logic [9:0] ctl(input logic [7:0] b);
    return five_wire_mode ? {b, 2'b00} : {2'b00, b};
  endfunction

  // Only visible lines carry pixels; all others carry blanking
  function automatic logic [9:0] pay_at(input int k, input int i);
    logic [9:0] p;
    p = (k == 3) ? pix_at(i) : 10'h01c;
    return five_wire_mode ? p : {2'b00, p[9:2]};
  endfunction

  // QCIF field: start, 2 black, 7 blank, 148 visible, end, 1 blank
  function automatic int qcif_kind(input int l);
    if (l == 0) return 4;
    if (l < 3) return 2;
    if (l < 10) return 1;
    if (l < 158) return 3;
    return (l == 158) ? 5 : 1;
  endfunction

  // Pixel index advances on each accepted word; the next value lands mid-cycle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) pix_idx <= 0;
    else if (pix_valid && pix_ready) pix_idx <= (pix_idx + 1) % line_len;
  end
  always @(negedge clk) begin
    pix_data <= pix_at(pix_idx);
    pix_valid <= run;
  end

  task automatic check_word(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_stat(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Config is set under reset so the first field start latches it
  task automatic start(input fmt_t f, input logic c, input logic x, input logic w, input int n);
    @(negedge clk);
    reset_n = 1'b0;
    run = 1'b0;
    video_format = f;
    compat_line_layout = c;
    extra_black_en = x;
    five_wire_mode = w;
    line_len = n;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    run = 1'b1;
    pos = 0;
  endtask

  task automatic wait_words(input int n);
    while (sink.words.size() < n) @(negedge clk);
  endtask

  // Walks one received line: open sequence, payload, close sequence
  task automatic check_line(input int l, input int k, input int n);
    logic [11:0] ln;
    ln = l[11:0];
    check_word(sink.words[pos], ctl(8'hff));
    check_word(sink.words[pos + 1], ctl(8'hff));
    check_word(sink.words[pos + 2], ctl(8'h00));
    check_word(sink.words[pos + 3], five_wire_mode ? PAIR[k] : ctl(CODE[k]));
    check_word(sink.words[pos + 4], ctl({1'b0, ln[11:6], ~^ln[11:6]}));
    check_word(sink.words[pos + 5], ctl({1'b0, ln[5:0], ~^ln[5:0]}));
    for (int i = 0; i < n; i++) begin
      check_word(sink.words[pos + 6 + i], pay_at(k, i));
    end
    pos = pos + 6 + n;
    check_word(sink.words[pos], ctl(8'hff));
    check_word(sink.words[pos + 1], ctl(8'hff));
    check_word(sink.words[pos + 2], ctl(8'h00));
    check_word(sink.words[pos + 3], five_wire_mode ? PAIR[0] : ctl(CODE[0]));
    check_word(sink.words[pos + 4], ctl((k == 3) ? 8'haa : 8'h07));
    check_word(sink.words[pos + 5], ctl(8'hff));
    pos = pos + 6;
  endtask

  initial begin
    start(fmt_qcif, 1'b1, 1'b0, 1'b0, 176);
    wait_words(20);
    check_stat({11'h000, pix_ready}, 12'h000);
    wait_words(160 * 188 + 20);
    check_stat({11'h000, field_second}, 12'h001);
    check_stat({9'h000, line_kind}, {9'h000, even_field_start_code});
    check_stat(line_number, 12'h000);
    wait_words(320 * 188);
    for (int f = 0; f < 2; f++) begin
      for (int l = 0; l < 160; l++) begin
        check_line(l, qcif_kind(l), 176);
      end
    end
    // PAL, compatible layout with extra black: 8 black, 1 blank, then visible
    start(fmt_pal, 1'b1, 1'b1, 1'b0, 352);
    wait_words(11 * 364);
    for (int l = 0; l < 11; l++) begin
      check_line(l, (l == 0) ? 4 : (l < 9) ? 2 : (l == 9) ? 1 : 3, 352);
    end
    // Five-wire, no compatible layout: 8 black then dark lines, black code
    start(fmt_ntsc, 1'b0, 1'b1, 1'b1, 352);
    wait_words(17 * 364);
    for (int l = 0; l < 17; l++) begin
      check_line(l, (l == 0) ? 4 : 2, 352);
    end
    check_stat(sink.code_errors[11:0], 12'h000);
    summarize();
  end

  // Cut a hang short well beyond the expected run of about 81k cycles
  initial begin
    repeat (95000) @(posedge clk);
    errors++;
    summarize();
  end
endmodule
